// ---- verilog/arpeggio_step_pattern_engine.sv ----
// arpeggiator step-pattern engine with its register port
`timescale 1ns/1ps
module arpeggio_step_pattern_engine import arp_pkg::*; (
  input  wire logic              i_core_clk,
  input  wire logic              i_rstn,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [DATA_W-1:0] i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic      [DATA_W-1:0] o_rdata,
  input  wire logic              i_tempo_tick,
  input  wire logic [KEYS-1:0]   i_held,
  input  wire logic              i_key_on,
  input  wire logic [NOTE_W-1:0] i_key,
  input  wire logic [NOTE_W-1:0] i_key_vel,
  input  wire logic              i_sustain,
  output logic                   o_trig,
  output logic                   o_gate,
  output logic      [NOTE_W-1:0] o_note,
  output logic      [NOTE_W-1:0] o_velocity,
  output logic                   o_poly,
  output logic      [NOTE_W-1:0] o_transpose,
  output logic                   o_porta,
  output logic      [STEP_W-1:0] o_step
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic {PLAY_IDLE, PLAY_RUN} play_e;

  arp_if lnk ();

  step_s             mem [STEPS];
  logic [DATA_W-1:0] ctrl;
  logic [DIV_W-1:0]  sync_div;
  logic [STEP_W-1:0] edit_step;
  logic [STEP_W-1:0] step_idx;
  play_e             play;
  logic [CNT_W-1:0]  fill_base;
  logic [CNT_W-1:0]  gate_cnt;
  logic              glide_prev;

  logic [STEP_W-1:0] len_m1;
  logic [NOTE_W-1:0] slot;
  logic              fill_on, solo, const_pitch, capture_on, is_poly;
  logic [CNT_W-1:0]  gate_len;
  logic [STEP_W-1:0] play_idx;
  step_s             cur;
  logic              wrap;
  logic [CNT_W-1:0]  raw_idx, eff_idx, max_idx, next_fill_base;
  logic [NOTE_W-1:0] key_rank;
  step_s             cap_word, bus_word;

  assign len_m1      = ctrl[CTRL_LEN_LSB +: STEP_W];
  assign slot        = ctrl[CTRL_SLOT_LSB +: NOTE_W];
  assign fill_on     = ctrl[CTRL_FILL_BIT];
  assign solo        = ctrl[CTRL_SOLO_BIT];
  assign const_pitch = ctrl[CTRL_CONST_BIT];
  assign capture_on  = ctrl[CTRL_CAPT_BIT];
  assign gate_len    = ctrl[CTRL_GATE_LSB +: CNT_W];
  assign is_poly     = slot >= POLY_SLOT_FIRST;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [NOTE_W-1:0] clamp_note(input logic [NOTE_W-1:0] v,
                                                   input logic poly);
    logic signed [NOTE_W-1:0] s;
    s = $signed(v);
    if (poly) begin
      if (s > $signed(POLY_MAX_SEMI)) clamp_note = POLY_MAX_SEMI;
      else if (s < -$signed(POLY_MAX_SEMI)) clamp_note = NOTE_W'(-POLY_MAX_SEMI);
      else clamp_note = v;
    end else begin
      if (v > MONO_MAX_IDX) clamp_note = MONO_MAX_IDX;
      else if (v == '0) clamp_note = NOTE_W'(1);
      else clamp_note = v;
    end
  endfunction

  function automatic step_s merge_step(input step_s old, input step_s nw,
                                       input logic poly);
    merge_step = nw;
    if (nw.gate == GATE_NORMAL || nw.gate == GATE_GLIDE) begin
      merge_step.note = clamp_note(nw.note, poly);
    end else begin
      merge_step.note = old.note;
    end
  endfunction

  // ----------------------------------------------------------------
  // sub-blocks
  // ----------------------------------------------------------------
  assign lnk.tempo_tick = i_tempo_tick;
  assign lnk.sync_div   = sync_div;
  assign lnk.held       = i_held;
  assign lnk.pick       = eff_idx;

  step_divider u_div (
    .i_core_clk (i_core_clk),
    .i_rstn     (i_rstn),
    .lnk        (lnk.divider)
  );

  note_ranker u_rank (
    .lnk (lnk.ranker)
  );

  // ----------------------------------------------------------------
  // step selection
  // ----------------------------------------------------------------
  assign wrap     = play == PLAY_RUN && step_idx == len_m1;
  assign play_idx = (play == PLAY_IDLE || wrap) ? '0 : step_idx + STEP_W'(1);
  assign cur      = mem[play_idx];
  assign raw_idx  = CNT_W'(cur.note);
  // a new pass uses its rotated base from its own first step on
  assign next_fill_base = (wrap && max_idx != '0 && lnk.count != '0) ?
                          CNT_W'((fill_base + max_idx) % lnk.count) : fill_base;

  always_comb begin
    logic [CNT_W-1:0] tmp;
    tmp = raw_idx - CNT_W'(1) + next_fill_base;
    if (lnk.count == '0) begin
      eff_idx = '0;
    end else if (fill_on && !is_poly) begin
      eff_idx = CNT_W'(tmp % lnk.count) + CNT_W'(1);
    end else if (raw_idx > lnk.count) begin
      eff_idx = lnk.count;
    end else begin
      eff_idx = raw_idx;
    end
  end

  always_comb begin
    max_idx = '0;
    for (int i = 0; i < STEPS; i++) begin
      if (STEP_W'(i) <= len_m1 && (mem[i].gate == GATE_NORMAL || mem[i].gate == GATE_GLIDE)
          && CNT_W'(mem[i].note) > max_idx) begin
        max_idx = CNT_W'(mem[i].note);
      end
    end
  end

  always_comb begin
    key_rank = NOTE_W'(1);
    for (int i = 0; i < KEYS; i++) begin
      if (NOTE_W'(i) < i_key && i_held[i]) key_rank = key_rank + NOTE_W'(1);
    end
  end

  assign cap_word = '{gate: i_sustain ? GATE_TIE : GATE_NORMAL,
                      vel:  i_key_vel,
                      note: is_poly ? i_key - CAPTURE_ROOT : key_rank};
  assign bus_word = step_s'(i_wdata[$bits(step_s)-1:0]);

  // ----------------------------------------------------------------
  // register port and pattern memory
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ctrl      <= CTRL_RESET;
      sync_div  <= SYNC_RESET;
      edit_step <= '0;
      for (int i = 0; i < STEPS; i++) mem[i] <= STEP_RESET;
    end else if (i_wr) begin
      unique case (i_addr)
        REG_CTRL: ctrl <= i_wdata;
        REG_SYNC: sync_div <= i_wdata[DIV_W-1:0];
        REG_EDIT: edit_step <= i_wdata[STEP_W-1:0];
        REG_STEP: mem[edit_step] <= merge_step(mem[edit_step], bus_word, is_poly);
        default: ;
      endcase
    end else if (capture_on && i_key_on) begin
      mem[edit_step] <= merge_step(mem[edit_step], cap_word, is_poly);
      edit_step      <= edit_step == len_m1 ? '0 : edit_step + STEP_W'(1);
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rdata <= '0;
    end else if (i_rd) begin
      unique case (i_addr)
        REG_CTRL:   o_rdata <= ctrl;
        REG_SYNC:   o_rdata <= DATA_W'(sync_div);
        REG_EDIT:   o_rdata <= DATA_W'(edit_step);
        REG_STEP:   o_rdata <= DATA_W'(mem[edit_step]);
        REG_STATUS: begin
          o_rdata <= '0;
          o_rdata[STEP_W-1:0] <= step_idx;
          o_rdata[STAT_CNT_LSB +: CNT_W] <= lnk.count;
          o_rdata[STAT_RUN_BIT] <= play == PLAY_RUN;
          o_rdata[STAT_MAX_LSB +: CNT_W] <= max_idx;
        end
        default: o_rdata <= '0;
      endcase
    end else begin
      o_rdata <= '0;
    end
  end

  // ----------------------------------------------------------------
  // step sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      play      <= PLAY_IDLE;
      step_idx  <= '0;
      fill_base <= '0;
    end else if (lnk.step_tick) begin
      if (lnk.count == '0) begin
        play      <= PLAY_IDLE;
        step_idx  <= '0;
        fill_base <= '0;
      end else begin
        play     <= PLAY_RUN;
        step_idx <= play_idx;
        fill_base <= next_fill_base;
      end
    end
  end

  // ----------------------------------------------------------------
  // voice outputs
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_trig      <= 1'b0;
      o_gate      <= 1'b0;
      o_note      <= '0;
      o_velocity  <= '0;
      o_poly      <= 1'b0;
      o_transpose <= '0;
      o_step      <= '0;
      gate_cnt    <= '0;
    end else begin
      o_trig <= 1'b0;
      if (lnk.step_tick) begin
        o_step <= play_idx;
        o_poly <= is_poly;
        if (lnk.count == '0) begin
          o_gate <= 1'b0;
        end else begin
          unique case (cur.gate)
            GATE_REST: o_gate <= 1'b0;
            GATE_TIE: begin
              o_gate   <= 1'b1;
              gate_cnt <= gate_len;
            end
            default: begin
              o_trig      <= 1'b1;
              o_gate      <= 1'b1;
              gate_cnt    <= gate_len;
              o_velocity  <= cur.vel;
              o_note      <= lnk.picked;
              o_transpose <= (is_poly && !const_pitch) ? cur.note : '0;
            end
          endcase
        end
      end else if (i_tempo_tick && o_gate) begin
        if (gate_cnt <= CNT_W'(1)) begin
          o_gate   <= 1'b0;
          gate_cnt <= '0;
        end else begin
          gate_cnt <= gate_cnt - CNT_W'(1);
        end
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      glide_prev <= 1'b0;
      o_porta    <= 1'b0;
    end else if (lnk.step_tick) begin
      o_porta    <= glide_prev;
      glide_prev <= lnk.count != '0 && cur.gate == GATE_GLIDE && solo;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);

  sequence s_play_step;
    lnk.step_tick && lnk.count != '0;
  endsequence
  sequence s_normal_step;
    s_play_step ##0 cur.gate == GATE_NORMAL;
  endsequence

  property p_wrap;
    s_play_step ##0 wrap |=> step_idx == '0 && o_step == '0;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("pattern did not wrap to its first step");

  property p_normal_trig;
    s_normal_step |=> o_trig && o_gate ##1 !o_trig;
  endproperty
  a_normal_trig: assert property (p_normal_trig)
    else $error("normal step did not retrigger for one cycle");

  property p_rest_silent;
    s_play_step ##0 cur.gate == GATE_REST |=> !o_trig && !o_gate;
  endproperty
  a_rest_silent: assert property (p_rest_silent)
    else $error("rest step sounded");

  property p_tie_hold;
    s_play_step ##0 cur.gate == GATE_TIE |=> !o_trig && o_gate;
  endproperty
  a_tie_hold: assert property (p_tie_hold)
    else $error("tie step retriggered or dropped the gate");

  property p_glide_solo;
    lnk.step_tick && !solo |=> !glide_prev;
  endproperty
  a_glide_solo: assert property (p_glide_solo)
    else $error("glide armed without single-voice polyphony");

  property p_porta_once;
    lnk.step_tick && !glide_prev |=> !o_porta;
  endproperty
  a_porta_once: assert property (p_porta_once)
    else $error("portamento left on after the glide transition");

  property p_clamp_highest;
    lnk.count != '0 && !fill_on && raw_idx > lnk.count |-> eff_idx == lnk.count;
  endproperty
  a_clamp_highest: assert property (p_clamp_highest)
    else $error("oversized index did not play the highest note");

  property p_mono_limit;
    max_idx <= CNT_W'(MONO_MAX_IDX) || is_poly;
  endproperty
  a_mono_limit: assert property (p_mono_limit)
    else $error("mono pattern index above its limit");

  property p_poly_range;
    o_poly |-> $signed(o_transpose) <= $signed(POLY_MAX_SEMI)
               && $signed(o_transpose) >= -$signed(POLY_MAX_SEMI);
  endproperty
  a_poly_range: assert property (p_poly_range)
    else $error("poly transposition out of range");

  property p_slot_kind;
    lnk.step_tick |=> o_poly == $past(is_poly);
  endproperty
  a_slot_kind: assert property (p_slot_kind)
    else $error("pattern kind does not follow the slot number");
endmodule // arpeggio_step_pattern_engine

// ---- include/arp_pkg.sv ----
// constants and types of the arpeggio step-pattern engine
package arp_pkg;
  // ----------------------------------------------------------------
  // widths and sizes
  // ----------------------------------------------------------------
  localparam int ADDR_W  = 4;
  localparam int DATA_W  = 32;
  localparam int STEPS   = 64;
  localparam int STEP_W  = 6;
  localparam int NOTE_W  = 7;
  localparam int KEYS    = 128;
  localparam int CNT_W   = 8;
  localparam int DIV_W   = 8;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] REG_CTRL   = 4'h0;
  localparam logic [ADDR_W-1:0] REG_SYNC   = 4'h1;
  localparam logic [ADDR_W-1:0] REG_EDIT   = 4'h2;
  localparam logic [ADDR_W-1:0] REG_STEP   = 4'h3;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_LEN_LSB   = 0;
  localparam int CTRL_SLOT_LSB  = 8;
  localparam int CTRL_FILL_BIT  = 16;
  localparam int CTRL_SOLO_BIT  = 17;
  localparam int CTRL_CONST_BIT = 18;
  localparam int CTRL_CAPT_BIT  = 19;
  localparam int CTRL_GATE_LSB  = 24;
  localparam int STAT_CNT_LSB   = 8;
  localparam int STAT_RUN_BIT   = 16;
  localparam int STAT_MAX_LSB   = 24;
  // ----------------------------------------------------------------
  // limits and reset values
  // ----------------------------------------------------------------
  localparam logic [NOTE_W-1:0] MONO_MAX_IDX    = 7'h0C;
  localparam logic [NOTE_W-1:0] POLY_MAX_SEMI   = 7'h24;
  localparam logic [NOTE_W-1:0] POLY_SLOT_FIRST = 7'h40;
  localparam logic [NOTE_W-1:0] CAPTURE_ROOT    = 7'h3C;
  localparam logic [DATA_W-1:0] CTRL_RESET      = 32'h0800_0007;
  localparam logic [DIV_W-1:0]  SYNC_RESET      = 8'h06;

  typedef enum logic [1:0] {GATE_NORMAL, GATE_TIE, GATE_REST, GATE_GLIDE} gate_e;

  typedef struct packed {
    gate_e             gate;
    logic [NOTE_W-1:0] vel;
    logic [NOTE_W-1:0] note;
  } step_s;

  localparam step_s STEP_RESET = '{gate: GATE_REST, vel: 7'h64, note: 7'h01};
endpackage

// ---- include/arp_if.sv ----
// links between the engine, its step divider and its note ranker
`timescale 1ns/1ps
interface arp_if;
  import arp_pkg::*;
  logic              tempo_tick;
  logic [DIV_W-1:0]  sync_div;
  logic              step_tick;
  logic [KEYS-1:0]   held;
  logic [CNT_W-1:0]  pick;
  logic [NOTE_W-1:0] picked;
  logic [CNT_W-1:0]  count;

  modport divider (input tempo_tick, input sync_div, output step_tick);
  modport ranker  (input held, input pick, output picked, output count);
  modport engine  (output tempo_tick, output sync_div, output held, output pick,
                   input step_tick, input picked, input count);
endinterface

// ---- verilog/step_divider.sv ----
// divides the shared tempo tick down to the step rate
`timescale 1ns/1ps
module step_divider import arp_pkg::*; (
  input  wire logic i_core_clk,
  input  wire logic i_rstn,
  arp_if.divider    lnk
);
  logic [DIV_W-1:0] tick_cnt;

  // ----------------------------------------------------------------
  // one step per sync_div tempo ticks
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      tick_cnt      <= '0;
      lnk.step_tick <= 1'b0;
    end else begin
      lnk.step_tick <= 1'b0;
      if (lnk.tempo_tick) begin
        if (tick_cnt + DIV_W'(1) >= lnk.sync_div) begin
          tick_cnt      <= '0;
          lnk.step_tick <= 1'b1;
        end else begin
          tick_cnt <= tick_cnt + DIV_W'(1);
        end
      end
    end
  end

  property p_step_from_tempo;
    @(posedge i_core_clk) disable iff (!i_rstn)
    lnk.step_tick |-> $past(lnk.tempo_tick);
  endproperty
  a_step_from_tempo: assert property (p_step_from_tempo)
    else $error("step tick without a tempo tick");

  property p_step_spacing;
    @(posedge i_core_clk) disable iff (!i_rstn)
    lnk.step_tick && lnk.sync_div > DIV_W'(1) |=> !lnk.step_tick;
  endproperty
  a_step_spacing: assert property (p_step_spacing)
    else $error("steps closer than the sync division");
endmodule // step_divider

// ---- verilog/note_ranker.sv ----
// ranks held keys from the lowest up and picks one by rank
`timescale 1ns/1ps
module note_ranker import arp_pkg::*; (
  arp_if.ranker lnk
);
  // ----------------------------------------------------------------
  // lowest held key is rank 1
  // ----------------------------------------------------------------
  always_comb begin
    logic [CNT_W-1:0] cnt;
    cnt        = '0;
    lnk.picked = '0;
    for (int i = 0; i < KEYS; i++) begin
      if (lnk.held[i]) begin
        cnt = cnt + CNT_W'(1);
        if (cnt == lnk.pick) begin
          lnk.picked = NOTE_W'(i);
        end
      end
    end
    lnk.count = cnt;
  end
endmodule // note_ranker

// ---- testbench/key_scan_model.sv ----
// keyboard scanner model presenting held keys and key presses
`timescale 1ns/1ps
module key_scan_model import arp_pkg::*; (
  input  wire logic              i_core_clk,
  input  wire logic              i_rstn,
  input  wire logic [KEYS-1:0]   i_keys,
  input  wire logic              i_press,
  input  wire logic [NOTE_W-1:0] i_pkey,
  input  wire logic [NOTE_W-1:0] i_pvel,
  output logic      [KEYS-1:0]   o_held,
  output logic                   o_key_on,
  output logic      [NOTE_W-1:0] o_key,
  output logic      [NOTE_W-1:0] o_key_vel
);
  // key lines carry meaning only beside the press pulse, so they toggle otherwise
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_held    <= '0;
      o_key_on  <= 1'b0;
      o_key     <= '0;
      o_key_vel <= '0;
    end else begin
      o_held    <= i_keys;
      o_key_on  <= i_press;
      o_key     <= i_press ? i_pkey : ~o_key;
      o_key_vel <= i_press ? i_pvel : ~o_key_vel;
    end
  end
endmodule // key_scan_model

// ---- testbench/arpeggio_step_pattern_engine_test.sv ----
// self-checking bench of the arpeggio step-pattern engine
`timescale 1ns/1ps
module arpeggio_step_pattern_engine_test import arp_pkg::*; ;
  logic              clk = 1'b0;
  logic              rstn = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic              wr = 1'b0;
  logic              rd = 1'b0;
  logic              tick = 1'b0;
  logic              press = 1'b0;
  logic              sus = 1'b0;
  logic [NOTE_W-1:0] pkey = '0;
  logic [NOTE_W-1:0] pvel = '0;
  logic [KEYS-1:0]   keys = '0;
  logic [KEYS-1:0]   kset;
  logic [KEYS-1:0]   held;
  logic              key_on;
  logic [NOTE_W-1:0] key;
  logic [NOTE_W-1:0] key_vel;
  logic [DATA_W-1:0] rdata;
  logic              trig;
  logic              gate;
  logic [NOTE_W-1:0] note;
  logic [NOTE_W-1:0] vel;
  logic              poly;
  logic [NOTE_W-1:0] transp;
  logic              porta;
  logic [STEP_W-1:0] step;
  logic [15:0]       lf;
  logic [DATA_W-1:0] d;
  logic [NOTE_W-1:0] k [3];
  logic [NOTE_W-1:0] vv [5];
  int                num_errors = 0;
  int                cmp_count = 0;
  int                cycles = 0;
  int                base;
  int                r;

  always #2.5 clk = ~clk;

  key_scan_model u_key_scan_model (.i_core_clk(clk), .i_rstn(rstn), .i_keys(keys),
    .i_press(press), .i_pkey(pkey), .i_pvel(pvel), .o_held(held), .o_key_on(key_on),
    .o_key(key), .o_key_vel(key_vel));

  arpeggio_step_pattern_engine u_arpeggio_step_pattern_engine (.i_core_clk(clk),
    .i_rstn(rstn), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .i_tempo_tick(tick), .i_held(held), .i_key_on(key_on), .i_key(key),
    .i_key_vel(key_vel), .i_sustain(sus), .o_trig(trig), .o_gate(gate), .o_note(note),
    .o_velocity(vel), .o_poly(poly), .o_transpose(transp), .o_porta(porta),
    .o_step(step));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic [31:0] step_word(input gate_e g, input logic [6:0] v,
                                            input logic [6:0] n);
    return {16'h0000, g, v, n};
  endfunction

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 8000) begin
      num_errors++;
      print_verdict();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (exp !== got) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic stp(input int i, input gate_e g, input logic [6:0] v, input logic [6:0] n);
    wr_reg(REG_EDIT, 32'(i));
    wr_reg(REG_STEP, step_word(g, v, n));
  endtask

  task automatic ctl(input int len, input int slot, input logic fill, input logic solo,
                     input logic cst, input logic capt);
    wr_reg(REG_CTRL, {8'h08, 4'h0, capt, cst, solo, fill, 1'b0, 7'(slot), 2'b00,
                      6'(len - 1)});
  endtask

  // one tempo tick; outputs are settled one edge after it is sampled
  task automatic tk();
    @(posedge clk);
    tick <= 1'b1;
    @(posedge clk);
    tick <= 1'b0;
    @(posedge clk);
    #1;
  endtask

  // an empty held set at a step stops playback and returns it to step 0
  task automatic restart();
    @(posedge clk);
    keys <= '0;
    tk();
    @(posedge clk);
    keys <= kset;
  endtask

  task automatic press_key(input logic [6:0] n, input logic [6:0] v, input logic s);
    @(posedge clk);
    press <= 1'b1;
    pkey <= n;
    pvel <= v;
    sus <= s;
    @(posedge clk);
    press <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    lf = 16'h0009;
    for (int i = 0; i < 5; i++) begin
      lf = lfsr_next(lf);
      vv[i] = lf[6:0] | 7'h01;
    end
    lf = lfsr_next(lf);
    k[0] = 7'h14 + 7'(lf[4:0]);
    k[1] = k[0] + 7'h01 + 7'(lf[7:5]);
    k[2] = k[1] + 7'h01 + 7'(lf[10:8]);
    kset = '0;
    for (int i = 0; i < 3; i++) kset[k[i]] = 1'b1;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    rd_reg(REG_CTRL, d);
    chk("ctrl reset", CTRL_RESET, d);
    rd_reg(REG_SYNC, d);
    chk("sync reset", 32'(SYNC_RESET), d);
    rd_reg(REG_STEP, d);
    chk("step reset", step_word(GATE_REST, 7'h64, 7'h01), d);
    rd_reg(4'h7, d);
    chk("unmapped", 32'h0000_0000, d);
    stp(0, GATE_NORMAL, vv[0], 7'h01);
    keys <= kset;
    for (int i = 0; i < 6; i++) begin
      tk();
      chk("trig sync", i == 5, trig);
    end
    wr_reg(REG_SYNC, 32'h0000_0001);
    $display("test reset and sync done");
    stp(2, GATE_NORMAL, vv[0], 7'h05);
    stp(2, GATE_TIE, vv[0], 7'h09);
    rd_reg(REG_STEP, d);
    chk("locked note", step_word(GATE_TIE, vv[0], 7'h05), d);
    stp(2, GATE_NORMAL, vv[0], 7'h0D);
    rd_reg(REG_STEP, d);
    chk("mono clamp", step_word(GATE_NORMAL, vv[0], 7'h0C), d);
    ctl(8, 0, 0, 0, 0, 1);
    wr_reg(REG_EDIT, 32'h0000_0000);
    press_key(k[1], vv[1], 1'b1);
    press_key(k[2], vv[2], 1'b0);
    ctl(8, 0, 0, 0, 0, 0);
    wr_reg(REG_EDIT, 32'h0000_0000);
    rd_reg(REG_STEP, d);
    chk("capture tie", step_word(GATE_TIE, vv[1], 7'h01), d);
    wr_reg(REG_EDIT, 32'h0000_0001);
    rd_reg(REG_STEP, d);
    chk("capture normal", step_word(GATE_NORMAL, vv[2], 7'h03), d);
    $display("test edit and capture done");
    ctl(5, 0, 0, 0, 1, 0);
    stp(0, GATE_NORMAL, vv[0], 7'h01);
    stp(1, GATE_NORMAL, vv[1], 7'h03);
    stp(2, GATE_TIE, vv[2], 7'h02);
    stp(3, GATE_REST, vv[3], 7'h01);
    stp(4, GATE_NORMAL, vv[4], 7'h05);
    restart();
    for (int p = 0; p < 10; p++) begin
      tk();
      r = p % 5;
      chk("step", r, step);
      chk("trig", r != 2 && r != 3, trig);
      chk("gate", r != 3, gate);
      if (r != 2 && r != 3) begin
        chk("note", k[r == 0 ? 0 : 2], note);
        chk("velocity", vv[r], vel);
        chk("transpose", 7'h00, transp);
      end
    end
    $display("test mono playback done");
    stp(1, GATE_NORMAL, vv[1], 7'h02);
    for (int f = 0; f < 2; f++) begin
      ctl(2, 0, f[0], 0, 0, 0);
      restart();
      base = 0;
      for (int s = 0; s < 6; s++) begin
        tk();
        r = f ? ((s % 2 + base) % 3) : s % 2;
        chk("fill note", k[r], note);
        if (s % 2 == 1) base = (base + 2) % 3;
      end
    end
    stp(0, GATE_GLIDE, vv[0], 7'h01);
    for (int m = 0; m < 2; m++) begin
      ctl(2, 0, 0, m[0], 0, 0);
      restart();
      for (int s = 0; s < 3; s++) begin
        tk();
        chk("porta", m == 1 && s == 1, porta);
      end
    end
    $display("test fill and glide done");
    ctl(3, 64, 1, 0, 0, 0);
    stp(0, GATE_NORMAL, vv[0], 7'h0C);
    stp(1, GATE_NORMAL, vv[1], 7'h7E);
    stp(2, GATE_NORMAL, vv[2], 7'h28);
    stp(3, GATE_NORMAL, vv[3], 7'h58);
    rd_reg(REG_STEP, d);
    chk("poly clamp", step_word(GATE_NORMAL, vv[3], 7'h5C), d);
    restart();
    for (int s = 0; s < 3; s++) begin
      tk();
      chk("poly", 1'b1, poly);
      chk("transpose", s == 0 ? 7'h0C : s == 1 ? 7'h7E : 7'h24, transp);
    end
    foreach (vv[i]) begin
      r = i == 0 ? 0 : i == 1 ? 63 : i == 2 ? 64 : 127;
      ctl(1, r, 0, 0, 0, 0);
      restart();
      tk();
      tk();
      chk("slot kind", r >= 64, poly);
      chk("one step", 6'h00, step);
    end
    ctl(64, 64, 0, 0, 0, 0);
    restart();
    for (int s = 0; s < 65; s++) begin
      tk();
      chk("long step", s % 64, step);
    end
    $display("test poly and length done");
    print_verdict();
  end
endmodule // arpeggio_step_pattern_engine_test
